// ===== inc/fp_exc_pkg.sv
// constants, field layouts and types for the post-compute exception checker
package fp_exc_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int CSR_W = 16;
	localparam int RES_W = 80;
	localparam int EXP_W = 18;
	localparam int FLAG_N = 6;
	localparam int IRQ_N = 3;

	typedef enum logic [1:0] {
		fmt_single = 2'h0,
		fmt_double = 2'h1,
		fmt_ext = 2'h2
	} format_t;

	typedef enum logic [1:0] {
		rnd_nearest = 2'h0,
		rnd_down = 2'h1,
		rnd_up = 2'h2,
		rnd_zero = 2'h3
	} rnd_t;

	// precision control codes of the stack unit
	localparam logic [1:0] PC_SINGLE = 2'h0;
	localparam logic [1:0] PC_DOUBLE = 2'h2;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_SIMD_CSR = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_STK_STATUS = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_STK_CTRL = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h0c;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h10;

	// flag positions inside a six-bit flag or mask group
	localparam int FLAG_OVF = 3;
	localparam int FLAG_UNF = 4;
	localparam int FLAG_PRE = 5;
	localparam logic [FLAG_N-1:0] FLG_OVF = 6'h08;
	localparam logic [FLAG_N-1:0] FLG_UNF = 6'h10;
	localparam logic [FLAG_N-1:0] FLG_PRE = 6'h20;

	// field positions
	localparam int SIMD_MASK_LSB = 7;
	localparam int SIMD_RND_LSB = 13;
	localparam int STK_MASK_LSB = 0;
	localparam int STK_PC_LSB = 8;
	localparam int STK_RND_LSB = 10;
	localparam int STK_RUP_BIT = 9;
	localparam logic [CSR_W-1:0] STK_RUP_MASK = 16'h0200;

	// writable bits and reset values
	localparam logic [CSR_W-1:0] SIMD_RW = 16'h7fbf;
	localparam logic [CSR_W-1:0] STK_STATUS_RW = 16'h023f;
	localparam logic [CSR_W-1:0] STK_CTRL_RW = 16'h0f3f;
	localparam logic [CSR_W-1:0] SIMD_RST = 16'h1f80;
	localparam logic [CSR_W-1:0] STK_STATUS_RST = 16'h0000;
	localparam logic [CSR_W-1:0] STK_CTRL_RST = 16'h033f;

	// interrupt status bits
	localparam int IRQ_OVF = 0;
	localparam int IRQ_UNF = 1;
	localparam int IRQ_PRE = 2;

	// unbiased exponent limits of the rounded result
	localparam logic signed [EXP_W-1:0] OVF_EXP_SINGLE = 18'sd128;
	localparam logic signed [EXP_W-1:0] OVF_EXP_DOUBLE = 18'sd1024;
	localparam logic signed [EXP_W-1:0] OVF_EXP_EXT = 18'sd16384;
	localparam logic signed [EXP_W-1:0] TINY_EXP_SINGLE = -18'sd126;
	localparam logic signed [EXP_W-1:0] TINY_EXP_DOUBLE = -18'sd1022;
	localparam logic signed [EXP_W-1:0] TINY_EXP_EXT = -18'sd16382;

	// encodings, right aligned in the result word
	localparam logic [RES_W-1:0] INF_SINGLE = 80'h7f800000;
	localparam logic [RES_W-1:0] INF_DOUBLE = 80'h7ff0000000000000;
	localparam logic [RES_W-1:0] INF_EXT = 80'h7fff8000000000000000;
	localparam logic [RES_W-1:0] MAXF_SINGLE = 80'h7f7fffff;
	localparam logic [RES_W-1:0] MAXF_DOUBLE = 80'h7fefffffffffffff;
	localparam logic [RES_W-1:0] MAXF_EXT = 80'h7ffeffffffffffffffff;
	localparam logic [RES_W-1:0] SIGN_SINGLE = 80'h80000000;
	localparam logic [RES_W-1:0] SIGN_DOUBLE = 80'h8000000000000000;
	localparam logic [RES_W-1:0] SIGN_EXT = 80'h80000000000000000000;

endpackage : fp_exc_pkg

// ===== inc/fp_exc_ifs.sv
// interfaces between the checker top, its bus port and its classifier
`timescale 1ns/1ps
`default_nettype none

interface reg_bus_if;
	import fp_exc_pkg::*;
	logic wr_en;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;
	modport port (output wr_en, output addr, output wdata, input rdata);
	modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface : reg_bus_if

interface class_if;
	import fp_exc_pkg::*;
	logic ovf;
	logic tiny;
	logic [RES_W-1:0] ovf_default;
	modport calc (output ovf, output tiny, output ovf_default);
	modport user (input ovf, input tiny, input ovf_default);
endinterface : class_if

`default_nettype wire

// ===== core/fp_exc_bus_port.sv
// avalon-mm slave handshake with one wait cycle per transfer
`timescale 1ns/1ps
`default_nettype none

module fp_exc_bus_port (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [fp_exc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [fp_exc_pkg::DATA_W-1:0] avs_writedata,
	output logic [fp_exc_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	reg_bus_if.port bus
);
	import fp_exc_pkg::*;

	logic wait_reg;
	logic [DATA_W-1:0] rdata_reg;
	wire req = avs_read | avs_write;

	// the write lands at the very edge the master sees waitrequest low
	assign bus.wr_en = avs_write & ~wait_reg;
	assign bus.addr = avs_address;
	assign bus.wdata = avs_writedata;
	assign avs_waitrequest = wait_reg;
	assign avs_readdata = rdata_reg;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wait_reg <= 1'b1;
			rdata_reg <= '0;
		end else if (req && wait_reg) begin
			wait_reg <= 1'b0;
			if (avs_read) begin
				rdata_reg <= bus.rdata;
			end
		end else begin
			wait_reg <= 1'b1;
		end
	end

endmodule : fp_exc_bus_port

`default_nettype wire

// ===== core/fp_exc_classify.sv
// overflow and tininess tests plus the masked overflow value
`timescale 1ns/1ps
`default_nettype none

module fp_exc_classify (
	input wire fp_exc_pkg::format_t fmt,
	input wire fp_exc_pkg::rnd_t rnd,
	input wire logic sign,
	input wire logic signed [fp_exc_pkg::EXP_W-1:0] exp_val,
	input wire logic is_zero,
	class_if.calc cls
);
	import fp_exc_pkg::*;

	wire logic signed [EXP_W-1:0] ovf_exp = (fmt == fmt_single) ? OVF_EXP_SINGLE :
		(fmt == fmt_double) ? OVF_EXP_DOUBLE : OVF_EXP_EXT;
	wire logic signed [EXP_W-1:0] tiny_exp = (fmt == fmt_single) ? TINY_EXP_SINGLE :
		(fmt == fmt_double) ? TINY_EXP_DOUBLE : TINY_EXP_EXT;
	wire logic [RES_W-1:0] inf_mag = (fmt == fmt_single) ? INF_SINGLE :
		(fmt == fmt_double) ? INF_DOUBLE : INF_EXT;
	wire logic [RES_W-1:0] max_mag = (fmt == fmt_single) ? MAXF_SINGLE :
		(fmt == fmt_double) ? MAXF_DOUBLE : MAXF_EXT;
	wire logic [RES_W-1:0] sign_mask = (fmt == fmt_single) ? SIGN_SINGLE :
		(fmt == fmt_double) ? SIGN_DOUBLE : SIGN_EXT;

	// infinity for nearest and where rounding runs away from zero
	wire logic use_inf = (rnd == rnd_nearest) | ((rnd == rnd_up) & ~sign) |
		((rnd == rnd_down) & sign); // [RULE_04] [RULE_05]

	// significand sits in [1,2), so the exponent alone decides
	assign cls.ovf = ~is_zero & (exp_val >= ovf_exp); // [RULE_01] [RULE_02]
	assign cls.tiny = ~is_zero & (exp_val < tiny_exp); // [RULE_07] [RULE_08]
	assign cls.ovf_default = (use_inf ? inf_mag : max_mag) | (sign ? sign_mask : '0); // [RULE_04]

endmodule : fp_exc_classify

`default_nettype wire

// ===== core/fp_post_compute_exception_check.sv
// post-computation overflow, underflow and inexact checker with avalon registers
// Notes on behaviour
// RULE_01: overflow is raised when the rounded magnitude exceeds the largest finite value.
// RULE_02: overflow threshold is 2^128, 2^1024 or 2^16384, inclusive, by format.
// RULE_03: masked overflow sets its flag, delivers a default value, no handler.
// RULE_04: masked overflow value: nearest gives signed infinity; down and up by sign.
// RULE_05: up with negative gives largest negative finite; toward zero gives signed largest.
// RULE_06: unmasked overflow sets flag, requests handler; simd keeps, stack writes biased.
// RULE_07: tininess judged on unbounded-exponent rounded result, honouring stack precision.
// RULE_08: tiny means below 2^-126, 2^-1022 or 2^-16382 and non-zero.
// RULE_09: masked underflow flags only tiny and inexact; delivered result is passed.
// RULE_10: unmasked underflow flags any tiny result, simd keeps, stack biased, handler.
// RULE_11: inexact is raised whenever the result is not exactly representable.
// RULE_12: masked inexact alone sets precision flag and writes the rounded result.
// RULE_13: unmasked inexact alone sets flag, writes rounded result, requests handler.
// RULE_14: inexact with masked over/underflow sets both flags; handler only if precision unmasked.
// RULE_15: inexact with unmasked over/underflow to a register sets both flags, handler.
// RULE_16: unmasked over/underflow on a memory store hides inexact and clears roundup bit.
// RULE_17: every class has a flag and a mask; mask picks default or handler.
// RULE_18: flags are sticky; simd flags sit in bits 0-5, masks in 7-12.
// RULE_19: one handler request pulse, same edge as the flag update, if any unmasked.
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fp_post_compute_exception_check (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [fp_exc_pkg::ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [fp_exc_pkg::DATA_W-1:0] avs_writedata,
	output logic [fp_exc_pkg::DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic op_valid,
	input wire logic op_stack_unit,
	input wire fp_exc_pkg::format_t op_format,
	input wire logic op_dest_mem,
	input wire logic op_sign,
	input wire logic signed [fp_exc_pkg::EXP_W-1:0] op_exp,
	input wire logic op_zero,
	input wire logic op_inexact,
	input wire logic op_round_up,
	input wire logic [fp_exc_pkg::RES_W-1:0] op_result,
	input wire logic [fp_exc_pkg::RES_W-1:0] op_biased_result,
	output logic res_valid,
	output logic res_write,
	output logic [fp_exc_pkg::RES_W-1:0] res_data,
	output logic handler_req,
	output logic irq
);
	import fp_exc_pkg::*;

	reg_bus_if bus ();
	class_if cls ();

	logic [CSR_W-1:0] simd_fp_control_status_reg;
	logic [CSR_W-1:0] stack_status_reg;
	logic [CSR_W-1:0] stack_ctrl_reg;
	logic [IRQ_N-1:0] irq_status_reg;
	logic [IRQ_N-1:0] irq_mask_reg;
	logic res_valid_reg;
	logic res_write_reg;
	logic [RES_W-1:0] res_data_reg;
	logic handler_req_reg;
	logic irq_reg;

	fp_exc_bus_port u_bus_port (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.bus(bus.port)
	);

	// control fields of the unit that issued the operation
	wire logic [1:0] simd_rnd_bits = simd_fp_control_status_reg[SIMD_RND_LSB +: 2];
	wire logic [1:0] stk_rnd_bits = stack_ctrl_reg[STK_RND_LSB +: 2];
	wire logic [1:0] stk_pc_bits = stack_ctrl_reg[STK_PC_LSB +: 2];
	wire rnd_t act_rnd = rnd_t'(op_stack_unit ? stk_rnd_bits : simd_rnd_bits);
	wire logic [FLAG_N-1:0] simd_masks = simd_fp_control_status_reg[SIMD_MASK_LSB +: FLAG_N];
	wire logic [FLAG_N-1:0] stk_masks = stack_ctrl_reg[STK_MASK_LSB +: FLAG_N];
	wire logic [FLAG_N-1:0] act_masks = op_stack_unit ? stk_masks : simd_masks; // [RULE_17]
	wire logic ovf_masked = act_masks[FLAG_OVF];
	wire logic unf_masked = act_masks[FLAG_UNF];
	wire logic pre_masked = act_masks[FLAG_PRE];

	// precision control narrows register results of the stack unit only
	wire format_t pc_format = (stk_pc_bits == PC_SINGLE) ? fmt_single :
		(stk_pc_bits == PC_DOUBLE) ? fmt_double : fmt_ext;
	wire logic use_pc = op_stack_unit & ~op_dest_mem;
	wire format_t eff_format = use_pc ? pc_format : op_format; // [RULE_07]

	fp_exc_classify u_classify (
		.fmt(eff_format),
		.rnd(act_rnd),
		.sign(op_sign),
		.exp_val(op_exp),
		.is_zero(op_zero),
		.cls(cls.calc)
	);

	// detection
	wire logic ovf_hit = op_valid & cls.ovf; // [RULE_01]
	wire logic tiny_hit = op_valid & cls.tiny;
	wire logic ovf_unm = ovf_hit & ~ovf_masked; // [RULE_06]
	wire logic unf_unm = tiny_hit & ~unf_masked; // [RULE_10]
	// masked underflow needs inexactness as well
	wire logic unf_raise = tiny_hit & (unf_masked ? op_inexact : 1'b1); // [RULE_09] [RULE_10]
	wire logic ou_unm = ovf_unm | unf_unm;
	wire logic mem_suppress = ou_unm & op_dest_mem; // [RULE_16]
	wire logic pre_raise = op_valid & op_inexact & ~mem_suppress; // [RULE_11] [RULE_14] [RULE_15]
	wire logic pre_unm = pre_raise & ~pre_masked; // [RULE_13] [RULE_14]
	wire logic handler_next = ou_unm | pre_unm; // [RULE_06] [RULE_10] [RULE_13] [RULE_15] [RULE_19]

	wire logic [FLAG_N-1:0] new_flags = (ovf_hit ? FLG_OVF : '0) |
		(unf_raise ? FLG_UNF : '0) | (pre_raise ? FLG_PRE : '0); // [RULE_14] [RULE_15]

	// destination write: masked overflow default, stack biased, otherwise rounded
	wire logic ovf_default_sel = ovf_hit & ovf_masked; // [RULE_03]
	wire logic biased_sel = ou_unm & use_pc; // [RULE_06] [RULE_10]
	wire logic keep_dest = ou_unm & ~use_pc; // [RULE_06] [RULE_10]
	wire logic [RES_W-1:0] res_sel = ovf_default_sel ? cls.ovf_default :
		biased_sel ? op_biased_result : op_result; // [RULE_03] [RULE_09] [RULE_12] [RULE_13]

	// register decode
	wire logic wr_simd = bus.wr_en & (bus.addr == OFS_SIMD_CSR);
	wire logic wr_stk_status = bus.wr_en & (bus.addr == OFS_STK_STATUS);
	wire logic wr_stk_ctrl = bus.wr_en & (bus.addr == OFS_STK_CTRL);
	wire logic wr_irq_status = bus.wr_en & (bus.addr == OFS_IRQ_STATUS);
	wire logic wr_irq_mask = bus.wr_en & (bus.addr == OFS_IRQ_MASK);
	wire logic [CSR_W-1:0] wdata_csr = bus.wdata[CSR_W-1:0];
	wire logic [IRQ_N-1:0] wdata_irq = bus.wdata[IRQ_N-1:0];
	wire logic [CSR_W-1:0] new_flags_w = {{(CSR_W-FLAG_N){1'b0}}, new_flags};

	// hardware sets win over a software clear in the same cycle
	wire logic simd_op = op_valid & ~op_stack_unit;
	wire logic stk_op = op_valid & op_stack_unit;
	wire logic [CSR_W-1:0] simd_base = (wr_simd ? wdata_csr : simd_fp_control_status_reg) & SIMD_RW;
	wire logic [CSR_W-1:0] simd_next = simd_base | (simd_op ? new_flags_w : '0); // [RULE_18]
	wire logic [CSR_W-1:0] stk_base = (wr_stk_status ? wdata_csr : stack_status_reg) &
		STK_STATUS_RW;
	// roundup bit follows each stack op, cleared on a suppressed store
	wire logic rup_new = ~mem_suppress & pre_raise & op_round_up; // [RULE_16]
	wire logic rup_val = stk_op ? rup_new : stk_base[STK_RUP_BIT];
	wire logic [CSR_W-1:0] stk_status_next = (stk_base & ~STK_RUP_MASK) |
		(rup_val ? STK_RUP_MASK : '0) | (stk_op ? new_flags_w : '0); // [RULE_18]
	wire logic [CSR_W-1:0] stk_ctrl_next = wr_stk_ctrl ? (wdata_csr & STK_CTRL_RW) :
		stack_ctrl_reg;

	// interrupt status, write one to clear
	wire logic [IRQ_N-1:0] irq_set = {pre_raise, unf_raise, ovf_hit};
	wire logic [IRQ_N-1:0] irq_clr = wr_irq_status ? wdata_irq : '0;
	wire logic [IRQ_N-1:0] irq_status_next = (irq_status_reg & ~irq_clr) | irq_set;
	wire logic [IRQ_N-1:0] irq_mask_next = wr_irq_mask ? wdata_irq : irq_mask_reg;

	// read mux, unmapped offsets read zero
	assign bus.rdata = (bus.addr == OFS_SIMD_CSR) ? {16'h0000, simd_fp_control_status_reg} :
		(bus.addr == OFS_STK_STATUS) ? {16'h0000, stack_status_reg} :
		(bus.addr == OFS_STK_CTRL) ? {16'h0000, stack_ctrl_reg} :
		(bus.addr == OFS_IRQ_STATUS) ? {29'h00000000, irq_status_reg} :
		(bus.addr == OFS_IRQ_MASK) ? {29'h00000000, irq_mask_reg} : 32'h00000000;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			simd_fp_control_status_reg <= SIMD_RST;
			stack_status_reg <= STK_STATUS_RST;
			stack_ctrl_reg <= STK_CTRL_RST;
			irq_status_reg <= '0;
			irq_mask_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			simd_fp_control_status_reg <= simd_next; // [RULE_18]
			stack_status_reg <= stk_status_next; // [RULE_16] [RULE_18]
			stack_ctrl_reg <= stk_ctrl_next;
			irq_status_reg <= irq_status_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg <= |(irq_status_next & irq_mask_next);
		end
	end

	// result stage lands on the same edge as the flags
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			res_valid_reg <= 1'b0;
			res_write_reg <= 1'b0;
			res_data_reg <= '0;
			handler_req_reg <= 1'b0;
		end else begin
			res_valid_reg <= op_valid;
			res_write_reg <= op_valid & ~keep_dest; // [RULE_06] [RULE_10]
			res_data_reg <= op_valid ? res_sel : res_data_reg;
			handler_req_reg <= op_valid & handler_next; // [RULE_19]
		end
	end

	assign res_valid = res_valid_reg;
	assign res_write = res_write_reg;
	assign res_data = res_data_reg;
	assign handler_req = handler_req_reg;
	assign irq = irq_reg;

endmodule : fp_post_compute_exception_check

`default_nettype wire

// ===== verif/fp_datapath_model.sv
// behavioural arithmetic datapath that hands one rounded result per call
`timescale 1ns/1ps
`default_nettype none

module fp_datapath_model (
	input wire logic sys_clk,
	output logic op_valid,
	output logic op_stack_unit,
	output fp_exc_pkg::format_t op_format,
	output logic op_dest_mem,
	output logic op_sign,
	output logic signed [fp_exc_pkg::EXP_W-1:0] op_exp,
	output logic op_zero,
	output logic op_inexact,
	output logic op_round_up,
	output logic [fp_exc_pkg::RES_W-1:0] op_result,
	output logic [fp_exc_pkg::RES_W-1:0] op_biased_result
);
	import fp_exc_pkg::*;

	initial begin
		op_format = fmt_single;
		{op_valid, op_stack_unit, op_dest_mem, op_sign, op_exp, op_zero} = '0;
		{op_inexact, op_round_up, op_result, op_biased_result} = '0;
	end

	// one-cycle pulse; result lines flip afterwards so a late sample cannot match
	task automatic issue(input logic s, input format_t f, input logic m, g,
			input logic signed [EXP_W-1:0] e, input logic z, x, u);
		@(posedge sys_clk);
		op_valid <= 1'b1;
		op_format <= f;
		{op_stack_unit, op_dest_mem, op_sign, op_exp, op_zero, op_inexact, op_round_up} <=
			{s, m, g, e, z, x, u};
		op_result <= {g, 61'h0, e};
		op_biased_result <= ~{g, 61'h0, e};
		@(posedge sys_clk);
		op_valid <= 1'b0;
		op_result <= ~op_result;
		op_biased_result <= ~op_biased_result;
	endtask : issue
endmodule : fp_datapath_model

`default_nettype wire

// ===== verif/fp_exc_chk.sv
// concurrent checks on the exception checker ports
`timescale 1ns/1ps
`default_nettype none

module fp_exc_chk (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic op_valid,
	input wire logic op_stack_unit,
	input wire fp_exc_pkg::format_t op_format,
	input wire logic op_dest_mem,
	input wire logic op_sign,
	input wire logic signed [fp_exc_pkg::EXP_W-1:0] op_exp,
	input wire logic op_zero,
	input wire logic op_inexact,
	input wire logic [fp_exc_pkg::RES_W-1:0] op_result,
	input wire logic res_valid,
	input wire logic res_write,
	input wire logic [fp_exc_pkg::RES_W-1:0] res_data,
	input wire logic handler_req,
	input wire logic irq
);
	import fp_exc_pkg::*;
	// simd only: stack register results follow precision control instead
	wire logic signed [EXP_W-1:0] ovf_exp = op_format == fmt_single ? OVF_EXP_SINGLE :
		op_format == fmt_double ? OVF_EXP_DOUBLE : OVF_EXP_EXT;
	wire logic signed [EXP_W-1:0] tiny_exp = op_format == fmt_single ? TINY_EXP_SINGLE :
		op_format == fmt_double ? TINY_EXP_DOUBLE : TINY_EXP_EXT;
	wire logic ovf = !op_zero && op_exp >= ovf_exp;
	wire logic tny = !op_zero && op_exp < tiny_exp;
	wire logic simd_op = op_valid && !op_stack_unit;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	property p_answer; op_valid |=> res_valid; endproperty
	a_answer: assert property (p_answer) else $error("no result after op");
	property p_req; handler_req |-> res_valid && $past(op_valid); endproperty
	a_req: assert property (p_req) else $error("stray handler request");
	property p_pass;
		simd_op && !ovf && !tny |=> res_write && res_data == $past(op_result);
	endproperty
	a_pass: assert property (p_pass) else $error("rounded result lost");
	property p_quiet; simd_op && !ovf && !tny && !op_inexact |=> !handler_req; endproperty
	a_quiet: assert property (p_quiet) else $error("handler on exact op");
	property p_either; simd_op && (ovf || tny) && !op_inexact |=> handler_req != res_write;
	endproperty
	a_either: assert property (p_either) else $error("mask choice broken");
	property p_stk; op_valid && op_stack_unit && !op_dest_mem |=> res_write; endproperty
	a_stk: assert property (p_stk) else $error("stack register not written");
	property p_neg;
		simd_op && ovf && op_sign && op_format == fmt_single |=>
			!res_write || res_data[31:0] inside {32'hff800000, 32'hff7fffff};
	endproperty
	a_neg: assert property (p_neg) else $error("bad negative default");
	// the request edge still sees the idle high, the next edge sees the answer
	property p_wait; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
	property p_stand; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_stand: assert property (p_stand) else $error("bus answer too long");
	property p_irq;
		$rose(irq) |-> res_valid || $past(avs_write && !avs_waitrequest);
	endproperty
	a_irq: assert property (p_irq) else $error("irq without cause");

	c_ovf: cover property (simd_op && ovf);
	c_req: cover property (handler_req);
	c_irq: cover property ($rose(irq));
endmodule : fp_exc_chk

bind fp_post_compute_exception_check fp_exc_chk u_chk (.sys_clk, .sys_rst, .avs_read,
	.avs_write, .avs_waitrequest, .op_valid, .op_stack_unit, .op_format, .op_dest_mem,
	.op_sign, .op_exp, .op_zero, .op_inexact, .op_result, .res_valid, .res_write, .res_data,
	.handler_req, .irq);

`default_nettype wire

// ===== verif/tb_fp_post_compute_exception_check.sv
// self-checking bench for the post-compute exception checker
`timescale 1ns/1ps
`default_nettype none
`define chk(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
	$display("unexpected at %0t got %h expected %h", $time, a, b); end end

module tb_fp_post_compute_exception_check;
	import fp_exc_pkg::*;
	logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, res_valid, res_write;
	logic op_valid, op_stack_unit, op_dest_mem, op_sign, op_zero, op_inexact, op_round_up;
	logic handler_req, irq, rw, hq;
	logic [ADDR_W-1:0] avs_address;
	logic [DATA_W-1:0] avs_writedata, avs_readdata, q;
	logic signed [EXP_W-1:0] op_exp;
	format_t op_format;
	logic [RES_W-1:0] op_result, op_biased_result, res_data, rd;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;

	fp_post_compute_exception_check DUT (.sys_clk, .sys_rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .op_valid,
		.op_stack_unit, .op_format, .op_dest_mem, .op_sign, .op_exp, .op_zero, .op_inexact,
		.op_round_up, .op_result, .op_biased_result, .res_valid, .res_write, .res_data,
		.handler_req, .irq);
	fp_datapath_model dp (.sys_clk, .op_valid, .op_stack_unit, .op_format, .op_dest_mem,
		.op_sign, .op_exp, .op_zero, .op_inexact, .op_round_up, .op_result, .op_biased_result);

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// whole run is under two hundred cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			final_report();
		end
	end

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge sys_clk);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task automatic rdc(input logic [ADDR_W-1:0] a);
		bus(1'b0, a, '0);
	endtask : rdc

	task automatic csr(input logic [15:0] v);
		bus(1'b1, OFS_SIMD_CSR, {16'h0, v});
	endtask : csr

	function automatic logic [RES_W-1:0] val(logic g, logic signed [EXP_W-1:0] e);
		return {g, 61'h0, e};
	endfunction : val

	function automatic logic [RES_W-1:0] dflt(rnd_t r, logic g);
		logic big;
		big = r == rnd_nearest || (r == rnd_up && !g) || (r == rnd_down && g);
		return (big ? INF_SINGLE : MAXF_SINGLE) | (g ? SIGN_SINGLE : '0);
	endfunction : dflt

	task automatic op(input logic s, input format_t f, input logic m, g,
			input logic signed [EXP_W-1:0] e, input logic z, x, u);
		dp.issue(s, f, m, g, e, z, x, u);
		#1;
		rw = res_write;
		rd = res_data;
		hq = handler_req;
		`chk(res_valid, 1'b1)
	endtask : op

	task automatic t_regs();
		rdc(OFS_SIMD_CSR);
		`chk(q, 32'h1f80)
		rdc(OFS_STK_CTRL);
		`chk(q, 32'h033f)
		rdc(5'h14);
		`chk(q, 32'h0)
		csr(16'hffff);
		rdc(OFS_SIMD_CSR);
		`chk(q, {16'h0, SIMD_RW})
	endtask : t_regs

	task automatic t_ovf();
		for (int r = 0; r < 4; r++) begin
			for (int g = 0; g < 2; g++) begin
				csr(SIMD_RST | 16'(r << SIMD_RND_LSB));
				op(1'b0, fmt_single, 1'b0, g[0], 18'sd128, 1'b0, 1'b1, 1'b0);
				`chk({rw, hq, rd}, {2'b10, dflt(rnd_t'(r), g[0])})
				rdc(OFS_SIMD_CSR);
				`chk(q[5:3], 3'b101)
			end
		end
		op(1'b0, fmt_double, 1'b0, 1'b1, 18'sd1024, 1'b0, 1'b0, 1'b0);
		`chk(rd, MAXF_DOUBLE | SIGN_DOUBLE)
		op(1'b0, fmt_ext, 1'b0, 1'b0, 18'sd16384, 1'b0, 1'b0, 1'b0);
		`chk(rd, MAXF_EXT)
		op(1'b0, fmt_ext, 1'b0, 1'b0, 18'sd16383, 1'b0, 1'b1, 1'b0);
		`chk(rd, val(1'b0, 18'sd16383))
	endtask : t_ovf

	task automatic t_unf();
		csr(SIMD_RST);
		op(1'b0, fmt_single, 1'b0, 1'b1, -18'sd127, 1'b0, 1'b0, 1'b0);
		`chk({rw, hq, rd}, {2'b10, val(1'b1, -18'sd127)})
		op(1'b0, fmt_double, 1'b0, 1'b0, -18'sd1023, 1'b0, 1'b1, 1'b0);
		rdc(OFS_SIMD_CSR);
		`chk(q[5:3], 3'b110)
		csr(16'h1780);
		op(1'b0, fmt_single, 1'b0, 1'b0, -18'sd126, 1'b0, 1'b0, 1'b0);
		`chk({rw, hq}, 2'b10)
		op(1'b0, fmt_ext, 1'b0, 1'b0, -18'sd16383, 1'b0, 1'b0, 1'b0);
		`chk({rw, hq}, 2'b01)
		op(1'b0, fmt_single, 1'b0, 1'b0, -18'sd200, 1'b1, 1'b0, 1'b0);
		`chk({rw, hq}, 2'b10)
		csr(16'h1b80);
		op(1'b0, fmt_single, 1'b0, 1'b0, 18'sd128, 1'b0, 1'b0, 1'b0);
		`chk({rw, hq}, 2'b01)
		csr(16'h0f80);
		op(1'b0, fmt_single, 1'b0, 1'b0, '0, 1'b0, 1'b1, 1'b0);
		`chk({rw, hq, rd}, {2'b11, val(1'b0, '0)})
		op(1'b0, fmt_single, 1'b0, 1'b0, 18'sd128, 1'b0, 1'b1, 1'b0);
		`chk({rw, hq}, 2'b11)
	endtask : t_unf

	task automatic t_stk();
		bus(1'b1, OFS_STK_CTRL, 32'h0337);
		op(1'b1, fmt_single, 1'b0, 1'b0, 18'sd16384, 1'b0, 1'b1, 1'b1);
		`chk({rw, hq, rd}, {2'b11, ~val(1'b0, 18'sd16384)})
		op(1'b1, fmt_single, 1'b0, 1'b0, 18'sd200, 1'b0, 1'b0, 1'b0);
		`chk({rw, hq, rd}, {2'b10, val(1'b0, 18'sd200)})
		bus(1'b1, OFS_STK_STATUS, '0);
		op(1'b1, fmt_single, 1'b1, 1'b0, 18'sd128, 1'b0, 1'b1, 1'b1);
		`chk({rw, hq}, 2'b01)
		rdc(OFS_STK_STATUS);
		`chk({q[9], q[5:3]}, 4'b0001)
		op(1'b1, fmt_single, 1'b0, 1'b0, '0, 1'b0, 1'b1, 1'b1);
		rdc(OFS_STK_STATUS);
		`chk({q[9], q[5:3]}, 4'b1101)
	endtask : t_stk

	task automatic t_irq();
		bus(1'b1, OFS_IRQ_MASK, '0);
		bus(1'b1, OFS_IRQ_STATUS, 32'h7);
		rdc(OFS_IRQ_STATUS);
		`chk(q[2:0], 3'h0)
		csr(SIMD_RST);
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		op(1'b0, fmt_single, 1'b0, 1'b0, -18'sd127, 1'b0, 1'b1, 1'b0);
		@(posedge sys_clk);
		#1;
		`chk(irq, 1'b0)
		op(1'b0, fmt_single, 1'b0, 1'b0, 18'sd128, 1'b0, 1'b0, 1'b0);
		op(1'b0, fmt_single, 1'b0, 1'b0, 18'sd3, 1'b0, 1'b0, 1'b0);
		`chk(irq, 1'b1)
		rdc(OFS_SIMD_CSR);
		`chk(q[5:3], 3'b111)
		bus(1'b1, OFS_IRQ_STATUS, 32'h1);
		@(posedge sys_clk);
		#1;
		`chk(irq, 1'b0)
		rdc(OFS_IRQ_STATUS);
		`chk(q[2:0], 3'h6)
	endtask : t_irq

	initial begin
		sys_rst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_ovf();
		t_unf();
		t_stk();
		t_irq();
		final_report();
	end
endmodule : tb_fp_post_compute_exception_check

`default_nettype wire
